// File: src/clkgen_pkg.sv
// Purpose: Shared constants for the clock generator and its stabilization counter.
// Assumes: Byte-wide internal CPU bus with 16-bit addresses.
// Notes:   Stabilization limits are exponents of crystal periods.
package clkgen_pkg;

  localparam logic [15:0] ADDR_LS_MODE   = 16'hFFA0;
  localparam logic [15:0] ADDR_CLK_MODE  = 16'hFFA1;
  localparam logic [15:0] ADDR_MAIN_OSC  = 16'hFFA2;
  localparam logic [15:0] ADDR_STAB_STAT = 16'hFFA3;
  localparam logic [15:0] ADDR_STAB_SEL  = 16'hFFA4;
  localparam logic [15:0] ADDR_BUS_WAIT  = 16'hFFFD;

  localparam logic [2:0] STAB_SEL_RESET = 3'h5;
  localparam logic [7:0] ZERO_BYTE      = 8'h00;

  localparam int MAIN_OSC_HALT_BIT = 7;
  localparam int CPU_SRC_SEL_BIT   = 0;
  localparam int CPU_SRC_STATE_BIT = 1;
  localparam int LS_STOP_BIT       = 0;
  localparam int TWO_WAIT_BIT      = 1;

  localparam int STAB_STAGES = 5;
  localparam int STAB_CNT_W  = 17;
  localparam int STAB_EXP [STAB_STAGES] = '{16, 15, 14, 13, 11};

  localparam int RESET_HOLD_TICKS = 17;
  localparam int WAIT_STATES      = 2;

  localparam logic [2:0] SEL_2P11 = 3'h1;
  localparam logic [2:0] SEL_2P13 = 3'h2;
  localparam logic [2:0] SEL_2P14 = 3'h3;
  localparam logic [2:0] SEL_2P15 = 3'h4;
  localparam logic [2:0] SEL_2P16 = 3'h5;

  typedef enum logic [2:0] {
    ST_RESET_HOLD,
    ST_RUN,
    ST_STOPPED,
    ST_STAB_WAIT
  } cg_state_t;

endpackage

// File: src/stab_if.sv
// Purpose: Carrier between the clock controller and the stabilization counter.
// Assumes: Single clock domain.
// Notes:   Status bit 4 is the shortest stage, bit 0 the longest.
`timescale 1ns/1ps
interface stab_if;
  import clkgen_pkg::*;
  logic                   clear;
  logic                   tick;
  logic [2:0]             sel;
  logic [STAB_STAGES-1:0] status;
  logic                   done;
  modport ctrl (output clear, output tick, output sel, input status, input done);
  modport cnt  (input clear, input tick, input sel, output status, output done);
endinterface

// File: src/stab_counter.sv
// Purpose: Crystal oscillation stabilization counter with stage status.
// Assumes: tick is a one-cycle pulse per crystal period, only while oscillating.
// Notes:   Prohibited select codes are treated as the longest wait.
`timescale 1ns/1ps
module stab_counter
  import clkgen_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  stab_if.cnt       sif
);

  logic [STAB_CNT_W-1:0] cnt_q;
  logic [STAB_CNT_W-1:0] limit;
  logic                  at_limit;

  always_comb
  begin
    unique case (sif.sel)
      SEL_2P11: limit = STAB_CNT_W'(1) << STAB_EXP[4];
      SEL_2P13: limit = STAB_CNT_W'(1) << STAB_EXP[3];
      SEL_2P14: limit = STAB_CNT_W'(1) << STAB_EXP[2];
      SEL_2P15: limit = STAB_CNT_W'(1) << STAB_EXP[1];
      default:  limit = STAB_CNT_W'(1) << STAB_EXP[0];
    endcase
  end

  assign at_limit = (cnt_q >= limit);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt_q <= '0;
    else if (sif.clear)
      cnt_q <= '0;
    else if (sif.tick && !at_limit)
      cnt_q <= cnt_q + STAB_CNT_W'(1);
  end

  genvar g;
  generate
    for (g = 0; g < STAB_STAGES; g++)
    begin : g_stage
      assign sif.status[g] = (cnt_q >= (STAB_CNT_W'(1) << STAB_EXP[g]));
    end
  endgenerate

  assign sif.done = at_limit;

endmodule

// File: src/clock_gen.sv
// Purpose: Clock generator control: oscillator enables, STOP release wait, CPU clock
//          enables, prescaler and peripheral wait insertion.
// Assumes: Oscillator ticks and run flags arrive from outside and are synchronised here.
// Notes:   CPU clock delivery is a one-cycle enable pulse per divided source period.
//
// Behaviour
// - Hold the CPU after STOP release until the selected wait elapses on crystal.
// - Select codes 1..5 mean 2^11,13,14,15,16 crystal periods; others prohibited.
// - Select register resets to 05H, byte writes only, bits 2..0 used.
// - Counter stops at the selected limit; status shows no later stages.
// - Counting starts only once the crystal actually oscillates.
// - Wait bit 1: zero gives no wait, one gives two wait states.
// - Wait register clears to 00H on reset; bit and byte writes allowed.
// - Main oscillator halt bit starts and stops both high-speed oscillators.
// - Internal high-speed oscillator self-starts after reset when option picks it.
// - Low-speed oscillator self-starts after reset release.
// - Low-speed clock feeds CPU, watchdog and timer H1.
// - Option fixes low-speed oscillator stoppable or not; mode register acts if stoppable.
// - Prescaler divides the selected CPU clock source, low-speed or high-speed.
// - CPU runs from the low-speed clock without waiting for the crystal.
// - Source select 0 low-speed, 1 high-speed; read-only bit shows actual source.
// - After reset, CPU clock withheld for 17 low-speed cycles.
`timescale 1ns/1ps
module clock_gen
  import clkgen_pkg::*;
#(
  parameter int PRESCALE_DIV = 1
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_byte_we,
  input  wire logic        bus_bit_we,
  input  wire logic [2:0]  bus_bit_idx,
  input  wire logic        bus_bit_val,
  input  wire logic        bus_re,
  output logic      [7:0]  bus_rdata,
  input  wire logic        stop_enter,
  input  wire logic        stop_release,
  input  wire logic        periph_req,
  output logic             periph_wait,
  input  wire logic        opt_hs_internal,
  input  wire logic        opt_ls_stoppable,
  input  wire logic        xtal_tick,
  input  wire logic        xtal_running,
  input  wire logic        hs_int_tick,
  input  wire logic        ls_tick,
  output logic             xtal_osc_en,
  output logic             hs_int_osc_en,
  output logic             ls_osc_en,
  output logic             cpu_hold,
  output logic             cpu_clk_en,
  output logic             wdt_clk_en,
  output logic             tmh1_clk_en,
  output logic             two_wait_enable
);

  localparam int PRE_W = $clog2(PRESCALE_DIV + 1);
  localparam int HOLD_W = $clog2(RESET_HOLD_TICKS + 1);

  // Asynchronous inputs: two flops, then a third for edge detection.
  logic [5:0] s1_q;
  logic [5:0] s2_q;
  logic [2:0] s3_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= {opt_ls_stoppable, opt_hs_internal, xtal_running, hs_int_tick, xtal_tick, ls_tick};
      s2_q <= s1_q;
      s3_q <= s2_q[2:0];
    end
  end

  wire ls_edge    = s2_q[0] & ~s3_q[0];
  wire xtal_edge  = s2_q[1] & ~s3_q[1];
  wire hsi_edge   = s2_q[2] & ~s3_q[2];
  wire xtal_osc   = s2_q[3];
  wire hs_int_opt = s2_q[4];
  wire ls_stop_ok = s2_q[5];

  // Registers.
  logic [2:0] stab_sel_q;
  logic       two_wait_q;
  logic       main_osc_halt_q;
  logic       cpu_source_select_q;
  logic       cpu_source_state_q;
  logic       ls_stop_req_q;

  wire hit_sel   = (bus_addr == ADDR_STAB_SEL);
  wire hit_wait  = (bus_addr == ADDR_BUS_WAIT);
  wire hit_osc   = (bus_addr == ADDR_MAIN_OSC);
  wire hit_mode  = (bus_addr == ADDR_CLK_MODE);
  wire hit_ls    = (bus_addr == ADDR_LS_MODE);
  wire hit_stat  = (bus_addr == ADDR_STAB_STAT);
  wire [7:0] bit_mask = 8'h01 << bus_bit_idx;

  function automatic logic wbit(input logic hit, input int pos, input logic old,
                                input logic [7:0] wd, input logic [7:0] mk,
                                input logic bw, input logic bv, input logic by);
    logic r;
    r = old;
    if (hit && by)
      r = wd[pos];
    else if (hit && bw && mk[pos])
      r = bv;
    return r;
  endfunction

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stab_sel_q          <= STAB_SEL_RESET;
      two_wait_q          <= 1'b0;
      main_osc_halt_q     <= 1'b0;
      cpu_source_select_q <= 1'b0;
      ls_stop_req_q       <= 1'b0;
    end
    else
    begin
      if (hit_sel && bus_byte_we)
        stab_sel_q <= bus_wdata[2:0];
      two_wait_q <= wbit(hit_wait, TWO_WAIT_BIT, two_wait_q, bus_wdata, bit_mask,
                         bus_bit_we, bus_bit_val, bus_byte_we);
      main_osc_halt_q <= wbit(hit_osc, MAIN_OSC_HALT_BIT, main_osc_halt_q, bus_wdata,
                              bit_mask, bus_bit_we, bus_bit_val, bus_byte_we);
      cpu_source_select_q <= wbit(hit_mode, CPU_SRC_SEL_BIT, cpu_source_select_q,
                                  bus_wdata, bit_mask, bus_bit_we, bus_bit_val, bus_byte_we);
      ls_stop_req_q <= wbit(hit_ls, LS_STOP_BIT, ls_stop_req_q, bus_wdata, bit_mask,
                            bus_bit_we, bus_bit_val, bus_byte_we);
    end
  end

  // Stabilization counter.
  stab_if sif ();
  stab_counter u_stab
  (
    .clk (clk),
    .rst (rst),
    .sif (sif)
  );

  cg_state_t state_q;
  logic [HOLD_W-1:0] hold_q;

  assign sif.sel   = stab_sel_q;
  // Cleared on STOP, halt and release.
  assign sif.clear = stop_enter | stop_release | main_osc_halt_q;
  assign sif.tick  = xtal_edge & xtal_osc & ~hs_int_opt & (state_q != ST_STOPPED);

  wire hs_avail = hs_int_opt ? hs_int_osc_en : (xtal_osc & ~main_osc_halt_q);
  wire src_tick = cpu_source_state_q ? (hs_int_opt ? hsi_edge : xtal_edge) : ls_edge;

  // Controller.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ST_RESET_HOLD;
      hold_q  <= '0;
    end
    else
    begin
      unique case (state_q)
        ST_RESET_HOLD:
          if (ls_edge)
          begin
            if (hold_q == HOLD_W'(RESET_HOLD_TICKS - 1))
              state_q <= ST_RUN;
            hold_q <= hold_q + HOLD_W'(1);
          end
        ST_RUN:
          if (stop_enter)
            state_q <= ST_STOPPED;
        // Crystal source waits for the counter.
        ST_STOPPED:
          if (stop_release)
            state_q <= (cpu_source_state_q && !hs_int_opt) ? ST_STAB_WAIT : ST_RUN;
        ST_STAB_WAIT:
          if (sif.done)
            state_q <= ST_RUN;
      endcase
    end
  end

  // Prescaler on the selected CPU clock source, low-speed or high-speed.
  logic [PRE_W-1:0] pre_q;
  wire pre_wrap = (pre_q == PRE_W'(PRESCALE_DIV - 1));

  // Actual source follows select once available.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cpu_source_state_q <= 1'b0;
      pre_q              <= '0;
    end
    else
    begin
      if (!cpu_source_select_q || hs_avail)
        cpu_source_state_q <= cpu_source_select_q;
      if (src_tick)
        pre_q <= pre_wrap ? '0 : pre_q + PRE_W'(1);
    end
  end

  // Peripheral wait states.
  logic [1:0] wait_q;

  // Outputs from flops; all oscillators stopped while reset is held.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      xtal_osc_en     <= 1'b0;
      hs_int_osc_en   <= 1'b0;
      ls_osc_en       <= 1'b0;
      cpu_hold        <= 1'b1;
      cpu_clk_en      <= 1'b0;
      wdt_clk_en      <= 1'b0;
      tmh1_clk_en     <= 1'b0;
      two_wait_enable <= 1'b0;
      periph_wait     <= 1'b0;
      wait_q          <= '0;
      bus_rdata       <= ZERO_BYTE;
    end
    else
    begin
      // Halt bit gates both high-speed oscillators.
      xtal_osc_en   <= ~hs_int_opt & ~main_osc_halt_q & (state_q != ST_STOPPED);
      hs_int_osc_en <= hs_int_opt & ~main_osc_halt_q & (state_q != ST_STOPPED);
      // Mode register acts only if stoppable.
      ls_osc_en   <= ~(ls_stop_ok & ls_stop_req_q);
      // CPU released from reset hold on low-speed clock alone.
      cpu_hold    <= (state_q != ST_RUN);
      cpu_clk_en  <= src_tick & pre_wrap & (state_q == ST_RUN);
      // Low-speed clock to watchdog and timer H1.
      wdt_clk_en  <= ls_edge;
      tmh1_clk_en <= ls_edge;
      two_wait_enable <= two_wait_q;
      if (periph_req && two_wait_q)
        wait_q <= 2'(WAIT_STATES);
      else if (wait_q != '0)
        wait_q <= wait_q - 2'h1;
      periph_wait <= (periph_req && two_wait_q) || (wait_q > 2'h1);
      if (bus_re)
      begin
        bus_rdata <= ZERO_BYTE;
        if (hit_sel)
          bus_rdata <= {5'h00, stab_sel_q};
        if (hit_wait)
          bus_rdata[TWO_WAIT_BIT] <= two_wait_q;
        if (hit_osc)
          bus_rdata[MAIN_OSC_HALT_BIT] <= main_osc_halt_q;
        if (hit_mode)
          bus_rdata <= {6'h00, cpu_source_state_q, cpu_source_select_q};
        if (hit_ls)
          bus_rdata[LS_STOP_BIT] <= ls_stop_req_q;
        if (hit_stat)
          bus_rdata <= {3'h0, sif.status};
      end
    end
  end

endmodule

// File: verif/clock_gen_asserts.sv
// Purpose: Port-level assertions for the clock generator.
// Assumes: One clock domain; rst is asynchronous and active high.
// Notes:   Bound to clock_gen and sees only its ports.
`timescale 1ns/1ps
module clock_gen_asserts
  import clkgen_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0]  bus_wdata,
  input wire logic        bus_byte_we,
  input wire logic        bus_bit_we,
  input wire logic [2:0]  bus_bit_idx,
  input wire logic        bus_bit_val,
  input wire logic        bus_re,
  input wire logic [7:0]  bus_rdata,
  input wire logic        stop_enter,
  input wire logic        periph_req,
  input wire logic        periph_wait,
  input wire logic        opt_ls_stoppable,
  input wire logic        ls_tick,
  input wire logic        xtal_osc_en,
  input wire logic        ls_osc_en,
  input wire logic        cpu_hold,
  input wire logic        two_wait_enable
);
  logic       ls_prev_q;
  logic [4:0] ls_cnt_q;
  logic       seen_q;
  wire        wait_byte = bus_byte_we && (bus_addr == ADDR_BUS_WAIT);
  wire        wait_bit  = bus_bit_we && (bus_addr == ADDR_BUS_WAIT) && (bus_bit_idx == 3'h1);

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Raw low-speed edges are counted here; the design synchronises them, so its count only lags.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ls_prev_q <= 1'b0;
      ls_cnt_q  <= 5'h00;
      seen_q    <= 1'b0;
    end
    else
    begin
      ls_prev_q <= ls_tick;
      if (ls_tick && !ls_prev_q && ls_cnt_q != 5'h1F)
        ls_cnt_q <= ls_cnt_q + 5'h01;
      if (!cpu_hold)
        seen_q <= 1'b1;
    end
  end

  AST_WAIT_PULSE: assert property (
    periph_req && two_wait_enable && !periph_wait |=> periph_wait [*2] ##1 !periph_wait)
    else $error("wait pulse not two cycles");
  AST_NO_WAIT: assert property (
    periph_req && !two_wait_enable && !periph_wait |=> !periph_wait)
    else $error("wait inserted while disabled");
  AST_STOP_HOLD: assert property (
    stop_enter && !cpu_hold |-> ##2 cpu_hold)
    else $error("cpu not held after stop");
  AST_STOP_XTAL: assert property (
    stop_enter && !cpu_hold |-> ##2 !xtal_osc_en)
    else $error("crystal still enabled in stop");
  AST_RESET_HOLD: assert property (
    $fell(cpu_hold) && !seen_q |-> ls_cnt_q inside {[17:19]})
    else $error("reset hold length wrong");
  AST_RDATA_HOLD: assert property (
    !$past(bus_re) |-> $stable(bus_rdata))
    else $error("read data changed without read");
  AST_WAIT_BYTE: assert property (
    wait_byte |-> ##2 two_wait_enable == $past(bus_wdata[TWO_WAIT_BIT], 2))
    else $error("byte write to wait bit lost");
  AST_WAIT_BIT: assert property (
    wait_bit |-> ##2 two_wait_enable == $past(bus_bit_val, 2))
    else $error("bit write to wait bit lost");
  AST_LS_ON: assert property (
    !opt_ls_stoppable && !$past(rst) |-> ls_osc_en)
    else $error("unstoppable low-speed oscillator stopped");
endmodule

bind clock_gen clock_gen_asserts u_chk (.clk, .rst, .bus_addr, .bus_wdata, .bus_byte_we,
  .bus_bit_we, .bus_bit_idx, .bus_bit_val, .bus_re, .bus_rdata, .stop_enter, .periph_req,
  .periph_wait, .opt_ls_stoppable, .ls_tick, .xtal_osc_en, .ls_osc_en, .cpu_hold,
  .two_wait_enable);

// File: verif/osc_stabilization_and_bus_wait_bench.sv
// Purpose: Self-checking bench for the clock generator.
// Assumes: Crystal period is 4 clocks, low-speed period 8 clocks.
// Notes:   Only the two shortest STOP waits run, to keep the run short.
`timescale 1ns/1ps
module osc_stabilization_and_bus_wait_bench
  import clkgen_pkg::*;
;
  logic        clk, rst, bus_byte_we, bus_bit_we, bus_bit_val, bus_re;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata, bus_rdata;
  logic [2:0]  bus_bit_idx;
  logic        stop_enter, stop_release, periph_req, periph_wait, opt_hs_internal;
  logic        opt_ls_stoppable, xtal_tick, xtal_running, hs_int_tick, ls_tick;
  logic        xtal_osc_en, hs_int_osc_en, ls_osc_en, cpu_hold, cpu_clk_en;
  logic        wdt_clk_en, tmh1_clk_en, two_wait_enable;
  int          n_fail = 0, tests_run = 0, cyc = 0, nc, nw, n;
  logic [2:0]  codes [2] = '{SEL_2P11, SEL_2P13};
  int          exps  [2] = '{11, 13};
  logic [7:0]  stats [2] = '{8'h10, 8'h18};

  clock_gen dut (.clk, .rst, .bus_addr, .bus_wdata, .bus_byte_we, .bus_bit_we, .bus_bit_idx,
    .bus_bit_val, .bus_re, .bus_rdata, .stop_enter, .stop_release, .periph_req, .periph_wait,
    .opt_hs_internal, .opt_ls_stoppable, .xtal_tick, .xtal_running, .hs_int_tick, .ls_tick,
    .xtal_osc_en, .hs_int_osc_en, .ls_osc_en, .cpu_hold, .cpu_clk_en, .wdt_clk_en,
    .tmh1_clk_en, .two_wait_enable);

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // The crystal keeps toggling even while not flagged running, so early counting shows up.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc[1:0] == 2'h3)
      ls_tick <= ~ls_tick;
    if (cyc[0])
    begin
      xtal_tick   <= ~xtal_tick;
      hs_int_tick <= ~hs_int_tick;
    end
    if (cyc == 90000)
    begin
      n_fail++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_addr    <= a;
    bus_wdata   <= d;
    bus_byte_we <= 1'b1;
    @(posedge clk);
    bus_byte_we <= 1'b0;
  endtask

  task automatic bw(input logic [15:0] a, input logic [2:0] i, input logic v);
    @(posedge clk);
    bus_addr    <= a;
    bus_bit_idx <= i;
    bus_bit_val <= v;
    bus_bit_we  <= 1'b1;
    @(posedge clk);
    bus_bit_we <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e, input string nm);
    @(posedge clk);
    bus_addr <= a;
    bus_re   <= 1'b1;
    @(posedge clk);
    bus_re <= 1'b0;
    #1;
    chk(nm, bus_rdata, e);
  endtask

  task automatic pw_check(input logic on);
    chk("two_wait", {7'h00, two_wait_enable}, {7'h00, on}); // mirror
    @(posedge clk);
    periph_req <= 1'b1;
    @(posedge clk);
    periph_req <= 1'b0;
    repeat (2)
    begin
      #1;
      chk("pwait", {7'h00, periph_wait}, {7'h00, on}); // wait length
      @(posedge clk);
    end
    #1;
    chk("pwait_end", {7'h00, periph_wait}, 8'h00); // wait end
  endtask

  task automatic cnt80;
    nc = 0;
    nw = 0;
    repeat (80)
    begin
      @(posedge clk);
      #1;
      nc += cpu_clk_en;
      nw += wdt_clk_en + tmh1_clk_en;
    end
  endtask

  initial
  begin
    {rst, bus_byte_we, bus_bit_we, bus_bit_val, bus_re, stop_enter, stop_release} = 7'h7F & 7'h40;
    {periph_req, opt_hs_internal, opt_ls_stoppable, xtal_tick, hs_int_tick, ls_tick} = 6'h00;
    {bus_addr, bus_wdata, bus_bit_idx} = 27'h0;
    xtal_running = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("ls_en", {7'h00, ls_osc_en}, 8'h01); // self start
    chk("xtal_en", {7'h00, xtal_osc_en}, 8'h01); // halt clear
    chk("hs_en", {7'h00, hs_int_osc_en}, 8'h00); // option off
    chk("hold", {7'h00, cpu_hold}, 8'h01); // held
    rd(ADDR_STAB_SEL, 8'h05, "sel_rst"); // reset value
    rd(ADDR_BUS_WAIT, ZERO_BYTE, "wait_rst"); // reset value
    rd(16'hFFF0, ZERO_BYTE, "unmapped");
    n = 0;
    while (cpu_hold !== 1'b0 && n < 400)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("run", {7'h00, cpu_hold}, 8'h00); // runs on low speed
    cnt80();
    chk("cpu_ls", 8'(nc), 8'h0A); // low-speed rate
    chk("ls_out", 8'(nw), 8'h14); // timer clocks
    wr(ADDR_BUS_WAIT, 8'h02); // reserved bits zero
    repeat (3) @(posedge clk);
    pw_check(1'b1); // two waits
    bw(ADDR_BUS_WAIT, 3'h1, 1'b0);
    rd(ADDR_BUS_WAIT, ZERO_BYTE, "wait_bit"); // bit write
    repeat (3) @(posedge clk);
    pw_check(1'b0); // no wait
    bw(ADDR_STAB_SEL, 3'h2, 1'b0);
    rd(ADDR_STAB_SEL, 8'h05, "sel_bitwr"); // byte only
    wr(ADDR_STAB_SEL, 8'hFF);
    rd(ADDR_STAB_SEL, 8'h07, "sel_mask"); // bits 2..0
    wr(ADDR_LS_MODE, 8'h01);
    repeat (4) @(posedge clk);
    #1;
    chk("ls_keep", {7'h00, ls_osc_en}, 8'h01); // not stoppable
    wr(ADDR_LS_MODE, 8'h00);
    wr(ADDR_MAIN_OSC, 8'h80);
    repeat (4) @(posedge clk);
    #1;
    chk("xtal_halt", {7'h00, xtal_osc_en}, 8'h00); // halted
    rd(ADDR_STAB_STAT, ZERO_BYTE, "stat_clr"); // cleared
    wr(ADDR_MAIN_OSC, 8'h00);
    wr(ADDR_CLK_MODE, 8'h01);
    repeat (8) @(posedge clk);
    rd(ADDR_CLK_MODE, 8'h03, "src"); // source state
    cnt80();
    chk("cpu_hs", 8'(nc), 8'h14); // crystal rate
    foreach (codes[i])
    begin
      wr(ADDR_STAB_SEL, {5'h00, codes[i]}); // set before stop
      @(posedge clk);
      stop_enter <= 1'b1;
      @(posedge clk);
      stop_enter <= 1'b0;
      repeat (3) @(posedge clk);
      xtal_running <= 1'b0;
      stop_release <= 1'b1;
      @(posedge clk);
      stop_release <= 1'b0;
      repeat (200) @(posedge clk);
      #1;
      chk("pre_osc", {7'h00, cpu_hold}, 8'h01); // no count before oscillation
      @(posedge clk);
      xtal_running <= 1'b1;
      n = 0;
      while (cpu_hold === 1'b1 && n < 40000)
      begin
        @(posedge clk);
        #1;
        n++;
      end
      chk("stab", 8'(n >= (4 << exps[i]) - 4 && n <= (4 << exps[i]) + 16), 8'h01);
      repeat (4000) @(posedge clk);
      rd(ADDR_STAB_STAT, stats[i], "stat_lim"); // stops at selected stage
    end
    // Low-speed CPU clock: no hold after release, software polls the status instead.
    wr(ADDR_CLK_MODE, 8'h00);
    repeat (8) @(posedge clk);
    stop_enter <= 1'b1;
    @(posedge clk);
    stop_enter <= 1'b0;
    repeat (3) @(posedge clk);
    stop_release <= 1'b1;
    @(posedge clk);
    stop_release <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk("ls_nohold", {7'h00, cpu_hold}, 8'h00); // no wait on low speed
    repeat (8300) @(posedge clk);
    rd(ADDR_STAB_STAT, 8'h10, "ls_poll"); // shortest stage reached
    // Second reset with the internal high-speed oscillator chosen by option.
    @(posedge clk);
    rst <= 1'b1;
    opt_hs_internal <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("hs_on", {7'h00, hs_int_osc_en}, 8'h01); // self start
    chk("xtal_off", {7'h00, xtal_osc_en}, 8'h00); // crystal unused
    n = 0;
    while (cpu_hold !== 1'b0 && n < 400)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("run2", {7'h00, cpu_hold}, 8'h00); // hold ends again
    wr(ADDR_CLK_MODE, 8'h01);
    repeat (8) @(posedge clk);
    stop_enter <= 1'b1;
    @(posedge clk);
    stop_enter <= 1'b0;
    repeat (3) @(posedge clk);
    stop_release <= 1'b1;
    @(posedge clk);
    stop_release <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk("hs_nohold", {7'h00, cpu_hold}, 8'h00); // software times the wait
    rd(ADDR_STAB_STAT, ZERO_BYTE, "hs_stat"); // status unusable
    cnt80();
    chk("cpu_hsi", 8'(nc), 8'h14); // internal high-speed rate
    results();
  end
endmodule
